//--- bench/dual_timer_event_counter_properties.sv
// Port assertions for the dual timer/event counter
`timescale 1ns/1ps
module timer_port_props (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire tmr_pkg::reg_req_t i_req,
  input wire logic [7:0] o_rdata,
  input wire logic i_port_a_bit3_dir_out,
  input wire logic o_freq_divider_out,
  input wire logic o_freq_divider_oe,
  input wire logic o_wakeup,
  input wire logic o_c0_irq_req,
  input wire logic o_c1_irq_req
);
  import tmr_pkg::*;
  logic irq0_wr;
  logic mapped;
  assign irq0_wr = i_req.wr && i_req.addr == ADDR_IRQ_FIRST;
  assign mapped = i_req.addr inside {[8'h0B:8'h12], ADDR_IRQ_SECOND};
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  a_rdata_idle: assert property (!i_req.rd |=> o_rdata == 8'h00)
    else $error("read data outside answer cycle");
  a_unmapped_zero: assert property (i_req.rd && !mapped |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_c1_spare_bits: assert property (i_req.rd && i_req.addr == ADDR_C1_CTRL |=> o_rdata[2:0] == 3'h0)
    else $error("spare control bits not zero");
  a_oe_follows_dir: assert property (i_rst_b |=> o_freq_divider_oe == $past(i_port_a_bit3_dir_out))
    else $error("output enable does not follow direction");
  a_freq_gated_low: assert property (i_req.wr && i_req.addr == ADDR_PORT_A && !i_req.wdata[PORT_FREQ_BIT]
    |-> ##[1:2] !o_freq_divider_out)
    else $error("frequency output not held low");
  a_c0_irq_off: assert property (irq0_wr && !i_req.wdata[IRQ_C0_ENABLE_BIT] |-> ##[1:2] !o_c0_irq_req)
    else $error("counter zero request while disabled");
  a_c1_irq_off: assert property (i_req.wr && i_req.addr == ADDR_IRQ_SECOND && !i_req.wdata[IRQ_C1_ENABLE_BIT]
    |-> ##[1:2] !o_c1_irq_req)
    else $error("counter one request while disabled");
  a_irq_has_cause: assert property ($rose(o_c0_irq_req)
    |-> $past(o_wakeup) || $past(o_wakeup, 2) || $past(irq0_wr) || $past(irq0_wr, 2))
    else $error("request rose without overflow or enable");
endmodule // timer_port_props
bind dual_timer_event_counter timer_port_props timer_port_props_inst (.i_core_clk, .i_rst_b, .i_req, .o_rdata,
  .i_port_a_bit3_dir_out, .o_freq_divider_out, .o_freq_divider_oe, .o_wakeup, .o_c0_irq_req, .o_c1_irq_req);

//--- bench/dual_timer_event_counter_test.sv
// Self-checking bench for the dual timer/event counter
`timescale 1ns/1ps
module dual_timer_event_counter_test;
  import tmr_pkg::*;
  logic i_core_clk, i_rst_b, clk32k, dir_out, freq, oe, wake, irq0, irq1, fq;
  reg_req_t req;
  logic [1:0] fire, idle, pins;
  logic [7:0] width, d, rdata, w;
  logic [15:0] r, v;
  int error_cnt, comparisons, cyc, t0, t1, e;
  initial begin
    i_core_clk = 0;
    forever #50 i_core_clk = ~i_core_clk;
  end
  initial begin
    clk32k = 0;
    forever #15259 clk32k = ~clk32k;
  end
  always @(posedge i_core_clk) cyc <= cyc + 1;
  dual_timer_event_counter dual_timer_event_counter_inst (.i_core_clk, .i_rst_b, .i_req(req), .o_rdata(rdata),
    .i_c0_event_pin(pins[0]), .i_c1_event_pin(pins[1]), .i_clk32k(clk32k), .i_port_a_bit3_dir_out(dir_out),
    .o_freq_divider_out(freq), .o_freq_divider_oe(oe), .o_wakeup(wake), .o_c0_irq_req(irq0), .o_c1_irq_req(irq1));
  for (genvar k = 0; k < 2; k++) begin : g_pin
    pin_pulse_model pin_pulse_model_inst (.i_clk(i_core_clk), .i_fire(fire[k]), .i_idle(idle[k]),
      .i_width(width), .o_pin(pins[k]));
  end
  // ---------------------------------------------------------------
  // Bus, checks and waits
  // ---------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      error_cnt++;
      $display("Error %0t: got %h expected %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic bus(input logic [7:0] a, input logic [7:0] wd, input logic wr);
    @(posedge i_core_clk);
    req <= '{addr: a, wdata: wd, wr: wr, rd: !wr};
    @(posedge i_core_clk);
    req <= '0;
    #1 d = rdata;
  endtask
  function automatic logic [7:0] ad(input int c, input int k);
    return (c != 0 ? ADDR_C1_LOW : ADDR_C0_LOW) + 8'(k);
  endfunction
  task automatic load(input int c, input logic [15:0] val);
    bus(ad(c, 0), val[7:0], 1'b1);
    bus(ad(c, 1), val[15:8], 1'b1);
  endtask
  task automatic rdcnt(input int c);
    bus(ad(c, 1), 8'h00, 1'b0);
    r[15:8] = d;
    bus(ad(c, 0), 8'h00, 1'b0);
    r[7:0] = d;
  endtask
  task automatic waitwake;
    int i;
    i = 0;
    do begin
      tick(1);
      i++;
    end while (wake !== 1'b1 && i < 8000);
    chk(16'(i < 8000), 16'h0001, 16'h0001);
    t0 = t1;
    t1 = cyc;
  endtask
  task automatic pulse(input int c, input logic [7:0] pw);
    @(posedge i_core_clk);
    fire[c] <= 1'b1;
    width <= pw;
    @(posedge i_core_clk);
    fire <= 2'b00;
  endtask
  task automatic conclude;
    $display("Comparisons %0d, errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    #(100 * 90000);
    error_cnt++;
    conclude();
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    req = '0;
    fire = 2'b00;
    idle = 2'b00;
    width = 8'h00;
    dir_out = 1'b1;
    i_rst_b = 1'b0;
    v = 16'($urandom(32'h185e));
    repeat (12) @(posedge i_core_clk);
    i_rst_b <= 1'b1;
    bus(ADDR_C0_CTRL, 8'h00, 1'b0);
    chk(16'(d), 16'(C0_CTRL_RESET), 16'(C0_CTRL_RESET));
    bus(ADDR_C1_CTRL, 8'h00, 1'b0);
    chk(16'(d), 16'(C1_CTRL_RESET), 16'(C1_CTRL_RESET));
    bus(8'h55, 8'hAA, 1'b1);
    bus(8'h55, 8'h00, 1'b0);
    chk(16'(d), 16'h0000, 16'h0000);
    for (int c = 0; c < 2; c++) begin
      v = 16'($urandom);
      load(c, v);
      rdcnt(c);
      chk(r, v, v);
      bus(ad(c, 0), ~v[7:0], 1'b1);
      w = ~v[7:0];
      bus(ad(c, 0), 8'h00, 1'b0);
      chk(16'(d), 16'(w), 16'(w));
      rdcnt(c);
      chk(r, v, v);
    end
    bus(ADDR_IRQ_FIRST, 8'h04, 1'b1);
    for (int p = 0; p < 8; p++) begin
      v = 16'hFFF0 + 16'($urandom % 8);
      bus(ADDR_C0_CTRL, 8'h00, 1'b1);
      bus(ADDR_IRQ_FIRST, 8'h04, 1'b1);
      load(0, v);
      bus(ADDR_C0_CTRL, {MODE_TIMER, 3'b010, 3'(p)}, 1'b1);
      waitwake();
      waitwake();
      chk(16'(t1 - t0), 16'((32'h10000 - 32'(v)) << p), 16'((32'h10000 - 32'(v)) << p));
      tick(2);
      chk(16'(irq0), 16'h0001, 16'h0001);
    end
    bus(ADDR_C0_CTRL, {MODE_TIMER, 3'b010, 3'b000}, 1'b1);
    waitwake();
    tick(4);
    fq = freq;
    waitwake();
    tick(4);
    chk(16'(freq), 16'(!fq), 16'(!fq));
    @(posedge i_core_clk);
    dir_out <= 1'b0;
    tick(3);
    chk(16'(oe), 16'h0000, 16'h0000);
    @(posedge i_core_clk);
    dir_out <= 1'b1;
    tick(3);
    chk(16'(oe), 16'h0001, 16'h0001);
    bus(ADDR_IRQ_FIRST, 8'h00, 1'b1);
    bus(ADDR_PORT_A, 8'hF7, 1'b1);
    for (int k = 0; k < 2; k++) begin
      waitwake();
      tick(4);
      chk(16'({irq0, freq}), 16'h0000, 16'h0000);
    end
    bus(ADDR_PORT_A, 8'hFF, 1'b1);
    bus(ADDR_C0_CTRL, 8'h00, 1'b1);
    load(0, 16'hFFF0);
    bus(ADDR_C0_CTRL, {MODE_TIMER, 3'b010, 3'b011}, 1'b1);
    waitwake();
    load(0, 16'hFFE0);
    rdcnt(0);
    chk(r, 16'hFFF0, 16'hFFFF);
    waitwake();
    waitwake();
    chk(16'(t1 - t0), 16'd256, 16'd256);
    bus(ADDR_C0_CTRL, 8'h00, 1'b1);
    bus(ADDR_IRQ_SECOND, 8'h01, 1'b1);
    for (int s = 0; s < 2; s++) begin
      v = (s != 0) ? 16'hFFFE : 16'hFFF0 + 16'($urandom % 8);
      load(1, v);
      bus(ADDR_C1_CTRL, {MODE_TIMER, 1'(s), 5'b10000}, 1'b1);
      waitwake();
      waitwake();
      e = (s != 0) ? 610 : (32'h10000 - 32'(v)) * 4;
      chk(16'(t1 - t0), 16'(e - s), 16'(e + 2 * s));
      tick(2);
      chk(16'(irq1), 16'h0001, 16'h0001);
      bus(ADDR_C1_CTRL, 8'h00, 1'b1);
      bus(ADDR_IRQ_SECOND, 8'h01, 1'b1);
    end
    for (int c = 0; c < 2; c++) begin
      for (int g = 0; g < 2; g++) begin
        bus(ad(c, 2), 8'h00, 1'b1);
        load(c, 16'hFFF0);
        bus(ad(c, 2), {MODE_EVENT, 2'b01, 1'(g), 3'b000}, 1'b1);
        pulse(c, 8'd40);
        tick(15);
        rdcnt(c);
        chk(r, 16'hFFF1 - 16'(g), 16'hFFF1 - 16'(g));
        tick(40);
        rdcnt(c);
        chk(r, 16'hFFF1, 16'hFFF1);
      end
      bus(ad(c, 2), 8'h00, 1'b1);
    end
    for (int g = 0; g < 2; g++) begin
      bus(ADDR_C0_CTRL, 8'h00, 1'b1);
      idle[0] <= 1'(g == 0);
      tick(5);
      load(0, 16'h0000);
      w = 8'(40 + $urandom % 40);
      bus(ADDR_C0_CTRL, {MODE_PULSE, 2'b01, 1'(g), 3'b000}, 1'b1);
      pulse(0, w);
      tick(int'(w) + 20);
      rdcnt(0);
      chk(r, 16'(w) - 16'h0001, 16'(w) + 16'h0001);
      v = r;
      bus(ADDR_C0_CTRL, 8'h00, 1'b0);
      chk(16'(d[CTRL_RUN_BIT]), 16'h0000, 16'h0000);
      pulse(0, w);
      tick(int'(w) + 20);
      rdcnt(0);
      chk(r, v, v);
    end
    conclude();
  end
endmodule // dual_timer_event_counter_test

//--- bench/pin_pulse_model.sv
// Far-side pin driver: one pulse of set width away from its idle level
`timescale 1ns/1ps
module pin_pulse_model (
  input wire logic i_clk,
  input wire logic i_fire,
  input wire logic i_idle,
  input wire logic [7:0] i_width,
  output logic o_pin
);
  logic [7:0] left_r;
  initial left_r = 8'h00;
  // Pin is a plain push-pull source, always driven, never floating
  always_ff @(posedge i_clk) begin
    if (i_fire) begin
      left_r <= i_width;
    end else if (left_r != 8'h00) begin
      left_r <= left_r - 8'h01;
    end
  end
  assign o_pin = (left_r != 8'h00) ? !i_idle : i_idle;
endmodule // pin_pulse_model

//--- hw/dual_timer_event_counter.sv
// Top level: two timer/event counters, prescalers, flags, frequency output and register port
`timescale 1ns/1ps
module dual_timer_event_counter #(
  parameter logic FREQ_SRC_SEL = 1'b0
) (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire tmr_pkg::reg_req_t i_req,
  output logic [7:0] o_rdata,
  input wire logic i_c0_event_pin,
  input wire logic i_c1_event_pin,
  input wire logic i_clk32k,
  input wire logic i_port_a_bit3_dir_out,
  output logic o_freq_divider_out,
  output logic o_freq_divider_oe,
  output logic o_wakeup,
  output logic o_c0_irq_req,
  output logic o_c1_irq_req
);
  import tmr_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [2:0] c0_pin_sync;
    logic [2:0] c1_pin_sync;
    logic [2:0] k32_sync;
    logic [6:0] psc;
    logic [1:0] div4;
    logic [7:0] rdata;
    logic [7:0] irq_first;
    logic [7:0] irq_second;
    logic [7:0] port_a;
    logic freq_tgl;
    logic freq_out;
    logic freq_oe;
    logic wakeup;
    logic c0_req;
    logic c1_req;
  } top_state_t;

  top_state_t st_r;
  top_state_t st_nxt;

  logic [7:0] c0_ctrl;
  logic [7:0] c1_ctrl;
  logic [7:0] c0_low;
  logic [7:0] c1_low;
  logic [7:0] c0_high;
  logic [7:0] c1_high;
  logic c0_ovf;
  logic c1_ovf;
  logic c0_tick;
  logic c1_tick;
  logic c0_rise;
  logic c0_fall;
  logic c1_rise;
  logic c1_fall;
  logic k32_rise;
  logic [2:0] psc_sel;
  logic wr;
  logic rd;
  logic sel_ovf;
  logic [7:0] rd_mux;

  logic sel_c0_low;
  logic sel_c0_high;
  logic sel_c0_ctrl;
  logic sel_c1_low;
  logic sel_c1_high;
  logic sel_c1_ctrl;
  logic sel_irq_first;
  logic sel_irq_second;
  logic sel_port_a;

  logic wr_c0_low;
  logic wr_c0_high;
  logic wr_c0_ctrl;
  logic wr_c1_low;
  logic wr_c1_high;
  logic wr_c1_ctrl;
  logic wr_irq_first;
  logic wr_irq_second;
  logic wr_port_a;

  logic rd_c0_high;
  logic rd_c1_high;
  logic rd_c0_cnt;
  logic rd_c1_cnt;

  // ---------------------------------------------------------------
  // Edge detect and internal clock paths
  // ---------------------------------------------------------------
  // Only stage 1 and 2 are read; stage 0 is the raw synchroniser flop
  assign c0_rise = st_r.c0_pin_sync[1] & ~st_r.c0_pin_sync[2]; // see R25
  assign c0_fall = ~st_r.c0_pin_sync[1] & st_r.c0_pin_sync[2]; // see R25
  assign c1_rise = st_r.c1_pin_sync[1] & ~st_r.c1_pin_sync[2]; // see R25
  assign c1_fall = ~st_r.c1_pin_sync[1] & st_r.c1_pin_sync[2]; // see R25
  assign k32_rise = st_r.k32_sync[1] & ~st_r.k32_sync[2];
  assign psc_sel = c0_ctrl[CTRL_PSC_LSB +: 3];

  always_comb begin
    // Divide by 2^n: tick when the low n prescaler bits are all ones
    unique case (psc_sel)
      3'h0: c0_tick = 1'b1; // see R15
      3'h1: c0_tick = st_r.psc[0]; // see R15
      3'h2: c0_tick = &st_r.psc[1:0]; // see R15
      3'h3: c0_tick = &st_r.psc[2:0]; // see R15
      3'h4: c0_tick = &st_r.psc[3:0]; // see R15
      3'h5: c0_tick = &st_r.psc[4:0]; // see R15
      3'h6: c0_tick = &st_r.psc[5:0]; // see R15
      3'h7: c0_tick = &st_r.psc[6:0]; // see R15
    endcase
    c1_tick = c1_ctrl[CTRL_CLKSEL_BIT] ? k32_rise : (st_r.div4 == DIV4_LAST); // see R2
  end

  assign wr = i_req.wr;
  assign rd = i_req.rd;

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  assign sel_c0_low = i_req.addr == ADDR_C0_LOW;
  assign sel_c0_high = i_req.addr == ADDR_C0_HIGH;
  assign sel_c0_ctrl = i_req.addr == ADDR_C0_CTRL;
  assign sel_c1_low = i_req.addr == ADDR_C1_LOW;
  assign sel_c1_high = i_req.addr == ADDR_C1_HIGH;
  assign sel_c1_ctrl = i_req.addr == ADDR_C1_CTRL;
  assign sel_irq_first = i_req.addr == ADDR_IRQ_FIRST;
  assign sel_irq_second = i_req.addr == ADDR_IRQ_SECOND;
  assign sel_port_a = i_req.addr == ADDR_PORT_A;

  assign wr_c0_low = wr & sel_c0_low; // see R3
  assign wr_c0_high = wr & sel_c0_high; // see R4
  assign wr_c0_ctrl = wr & sel_c0_ctrl;
  assign wr_c1_low = wr & sel_c1_low; // see R3
  assign wr_c1_high = wr & sel_c1_high; // see R4
  assign wr_c1_ctrl = wr & sel_c1_ctrl;
  assign wr_irq_first = wr & sel_irq_first;
  assign wr_irq_second = wr & sel_irq_second;
  assign wr_port_a = wr & sel_port_a; // see R21

  // Any read of a counter byte freezes that counter for the cycle
  assign rd_c0_high = rd & sel_c0_high; // see R5
  assign rd_c1_high = rd & sel_c1_high; // see R5
  assign rd_c0_cnt = rd & (sel_c0_high | sel_c0_low); // see R18
  assign rd_c1_cnt = rd & (sel_c1_high | sel_c1_low); // see R18

  // ---------------------------------------------------------------
  // Counters
  // ---------------------------------------------------------------
  tmr_counter_core u_c0 (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_ctrl_reset(C0_CTRL_RESET),
    .i_ctrl_wmask(C0_CTRL_WMASK),
    .i_int_tick(c0_tick),
    .i_pin_rise(c0_rise),
    .i_pin_fall(c0_fall),
    .i_pin_level(st_r.c0_pin_sync[2]),
    .i_wr_low(wr_c0_low),
    .i_wr_high(wr_c0_high),
    .i_wr_ctrl(wr_c0_ctrl),
    .i_rd_high(rd_c0_high),
    .i_rd_any(rd_c0_cnt),
    .i_wdata(i_req.wdata),
    .o_ctrl(c0_ctrl),
    .o_low_buf(c0_low),
    .o_count_high(c0_high),
    .o_overflow(c0_ovf)
  );

  tmr_counter_core u_c1 (
    .i_core_clk(i_core_clk),
    .i_rst_b(i_rst_b),
    .i_ctrl_reset(C1_CTRL_RESET),
    .i_ctrl_wmask(C1_CTRL_WMASK),
    .i_int_tick(c1_tick),
    .i_pin_rise(c1_rise),
    .i_pin_fall(c1_fall),
    .i_pin_level(st_r.c1_pin_sync[2]),
    .i_wr_low(wr_c1_low),
    .i_wr_high(wr_c1_high),
    .i_wr_ctrl(wr_c1_ctrl),
    .i_rd_high(rd_c1_high),
    .i_rd_any(rd_c1_cnt),
    .i_wdata(i_req.wdata),
    .o_ctrl(c1_ctrl),
    .o_low_buf(c1_low),
    .o_count_high(c1_high),
    .o_overflow(c1_ovf)
  );

  assign sel_ovf = FREQ_SRC_SEL ? c1_ovf : c0_ovf; // see R20

  // ---------------------------------------------------------------
  // Read data select
  // ---------------------------------------------------------------
  always_comb begin
    unique case (i_req.addr)
      ADDR_C0_LOW: rd_mux = c0_low; // see R6
      ADDR_C0_HIGH: rd_mux = c0_high; // see R5
      ADDR_C0_CTRL: rd_mux = c0_ctrl;
      ADDR_C1_LOW: rd_mux = c1_low; // see R6
      ADDR_C1_HIGH: rd_mux = c1_high; // see R5
      ADDR_C1_CTRL: rd_mux = c1_ctrl;
      ADDR_IRQ_FIRST: rd_mux = st_r.irq_first;
      ADDR_IRQ_SECOND: rd_mux = st_r.irq_second;
      ADDR_PORT_A: rd_mux = st_r.port_a;
      default: rd_mux = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.c0_pin_sync = {st_r.c0_pin_sync[1:0], i_c0_event_pin}; // see R25
    st_nxt.c1_pin_sync = {st_r.c1_pin_sync[1:0], i_c1_event_pin}; // see R25
    st_nxt.k32_sync = {st_r.k32_sync[1:0], i_clk32k};
    st_nxt.psc = st_r.psc + 7'h01;
    st_nxt.div4 = st_r.div4 + 2'h1;
    // Read data stands for one cycle only, zero otherwise
    st_nxt.rdata = rd ? rd_mux : 8'h00;

    if (wr_irq_first) begin
      st_nxt.irq_first = i_req.wdata & 8'h7F;
    end
    if (wr_irq_second) begin
      st_nxt.irq_second = i_req.wdata & 8'h77;
    end
    if (wr_port_a) begin
      st_nxt.port_a = i_req.wdata;
    end
    // Set after the write so a same-cycle overflow is not lost
    if (c0_ovf) begin
      st_nxt.irq_first[IRQ_C0_FLAG_BIT] = 1'b1; // see R9, R14
    end
    if (c1_ovf) begin
      st_nxt.irq_second[IRQ_C1_FLAG_BIT] = 1'b1; // see R9, R14
    end
    st_nxt.c0_req = st_r.irq_first[IRQ_C0_FLAG_BIT] & st_r.irq_first[IRQ_C0_ENABLE_BIT]; // see R22
    st_nxt.c1_req = st_r.irq_second[IRQ_C1_FLAG_BIT] & st_r.irq_second[IRQ_C1_ENABLE_BIT]; // see R22
    st_nxt.wakeup = c0_ovf | c1_ovf; // see R19
    if (sel_ovf) begin
      st_nxt.freq_tgl = ~st_r.freq_tgl; // see R23
    end
    st_nxt.freq_out = st_r.port_a[PORT_FREQ_BIT] & st_r.freq_tgl; // see R21, R24
    st_nxt.freq_oe = i_port_a_bit3_dir_out;
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
      st_r.port_a <= PORT_A_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_rdata = st_r.rdata;
  assign o_freq_divider_out = st_r.freq_out;
  assign o_freq_divider_oe = st_r.freq_oe;
  assign o_wakeup = st_r.wakeup;
  assign o_c0_irq_req = st_r.c0_req;
  assign o_c1_irq_req = st_r.c1_req;
endmodule // dual_timer_event_counter

//--- hw/tmr_counter_core.sv
// One 16-bit timer/event counter with byte-buffered access and overflow reload
`timescale 1ns/1ps
module tmr_counter_core (
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_ctrl_reset,
  input wire logic [7:0] i_ctrl_wmask,
  input wire logic i_int_tick,
  input wire logic i_pin_rise,
  input wire logic i_pin_fall,
  input wire logic i_pin_level,
  input wire logic i_wr_low,
  input wire logic i_wr_high,
  input wire logic i_wr_ctrl,
  input wire logic i_rd_high,
  input wire logic i_rd_any,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_ctrl,
  output logic [7:0] o_low_buf,
  output logic [7:0] o_count_high,
  output logic o_overflow
);
  import tmr_pkg::*;

  counter_state_t st_r;
  counter_state_t st_nxt;
  logic [1:0] mode;
  logic edge_sel;
  logic run;
  logic tick;
  logic start_edge;
  logic stop_edge;

  always_comb begin
    mode = st_r.ctrl[CTRL_MODE_LSB +: 2];
    edge_sel = st_r.ctrl[CTRL_EDGE_BIT];
    run = st_r.ctrl[CTRL_RUN_BIT];
    start_edge = edge_sel ? i_pin_rise : i_pin_fall; // see R11
    stop_edge = edge_sel ? i_pin_fall : i_pin_rise; // see R11
    st_nxt = st_r;
    st_nxt.overflow = 1'b0;
    // Reset value enters the register on the first edge out of reset
    st_nxt.ctrl_loaded = 1'b1;
    if (!st_r.ctrl_loaded) begin
      st_nxt.ctrl = i_ctrl_reset & i_ctrl_wmask;
    end
    tick = 1'b0;
    unique case (mode)
      MODE_EVENT: tick = edge_sel ? i_pin_fall : i_pin_rise; // see R7, R10
      MODE_TIMER: tick = i_int_tick; // see R7
      MODE_PULSE: begin
        // Edge driven, not level driven: a pin already active at run does not start
        if (run && !st_r.meas_active && !st_r.meas_done && start_edge) begin // see R12
          st_nxt.meas_active = 1'b1;
        end
        if (run && st_r.meas_active && stop_edge) begin
          st_nxt.meas_active = 1'b0;
          st_nxt.meas_done = 1'b1;
          st_nxt.ctrl[CTRL_RUN_BIT] = 1'b0; // see R13
        end
        tick = st_r.meas_active && i_int_tick;
      end
      default: tick = 1'b0;
    endcase
    // Reads freeze counting; a tick that meets a read is lost
    if (!run || i_rd_any) begin // see R18
      tick = 1'b0;
    end
    if (tick) begin
      if (st_r.count == COUNT_MAX) begin // see R8, R14
        st_nxt.count = st_r.preload;
        st_nxt.overflow = 1'b1;
      end else begin
        st_nxt.count = st_r.count + 16'h0001; // see R1
      end
    end
    if (i_wr_low) begin
      st_nxt.low_buf = i_wdata; // see R3
    end
    if (i_wr_high) begin
      st_nxt.preload = {i_wdata, st_r.low_buf}; // see R4, R17
      if (!run) begin
        st_nxt.count = {i_wdata, st_r.low_buf}; // see R16
      end
    end
    if (i_rd_high) begin
      st_nxt.low_buf = st_r.count[7:0]; // see R5
    end
    if (i_wr_ctrl) begin
      st_nxt.ctrl = i_wdata & i_ctrl_wmask;
      if (i_wdata[CTRL_RUN_BIT]) begin
        st_nxt.meas_done = 1'b0; // see R12
        st_nxt.meas_active = st_r.meas_active & i_pin_level & 1'b0;
      end
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_ctrl = st_r.ctrl_loaded ? st_r.ctrl : (i_ctrl_reset & i_ctrl_wmask);
  assign o_low_buf = st_r.low_buf; // see R6
  assign o_count_high = st_r.count[15:8];
  assign o_overflow = st_r.overflow;
endmodule // tmr_counter_core

//--- hw/tmr_pkg.sv
// Package: register map, field layout, reset values and types for the dual timer/event counter
//
// Summary of operation
// R1: Counter zero is a 16-bit up-counter fed by its pin or internal clock path.
// R2: Counter one internal clock is system clock over four, or the 32768Hz input.
// R3: Low byte write only fills the 8-bit holding buffer.
// R4: High byte write loads high byte plus held low byte into preload at once.
// R5: High byte read returns live high byte and copies live low byte to buffer.
// R6: Low byte read returns the holding buffer, never the live counter.
// R7: Mode field: 01 event count, 10 timer, 11 pulse width, 00 unused.
// R8: Event and timer modes count to FFFFH, then reload from preload and continue.
// R9: Overflow sets counter zero flag bit 6 and counter one flag bit 4.
// R10: Event mode edge select 1 counts falling edges, 0 counts rising edges.
// R11: Pulse width edge select 1 measures rising-to-falling, 0 falling-to-rising.
// R12: Finished measurement stays put; start edges ignored until run is set again.
// R13: Run clears itself at pulse width end; otherwise only software changes it.
// R14: Overflow in pulse width mode reloads and raises the flag like other modes.
// R15: Counter zero prescaler divides system clock by two to the field value.
// R16: Preload write while stopped also loads the counter.
// R17: Preload write while running only updates preload; counter runs on.
// R18: While software reads a counter its count clock is blocked.
// R19: Either overflow is a wake-up source.
// R20: Frequency output source is counter zero or one overflow, fixed by an option.
// R21: Port data bit set enables frequency output, clear disables it.
// R22: Cleared interrupt enable keeps overflow from requesting service in every mode.
// R23: Frequency output toggles per selected overflow, overflow rate over two.
// R24: Port data bit 0 holds the output pin low regardless of overflows.
// R25: Pin inputs are synchronised and edge detected before use.
package tmr_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_C0_LOW = 8'h0C;
  localparam logic [7:0] ADDR_C0_HIGH = 8'h0D;
  localparam logic [7:0] ADDR_C0_CTRL = 8'h0E;
  localparam logic [7:0] ADDR_C1_LOW = 8'h0F;
  localparam logic [7:0] ADDR_C1_HIGH = 8'h10;
  localparam logic [7:0] ADDR_C1_CTRL = 8'h11;
  localparam logic [7:0] ADDR_IRQ_FIRST = 8'h0B;
  localparam logic [7:0] ADDR_IRQ_SECOND = 8'h1E;
  localparam logic [7:0] ADDR_PORT_A = 8'h12;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_PSC_LSB = 0;
  localparam int CTRL_EDGE_BIT = 3;
  localparam int CTRL_RUN_BIT = 4;
  localparam int CTRL_CLKSEL_BIT = 5;
  localparam int CTRL_MODE_LSB = 6;
  localparam int IRQ_C0_ENABLE_BIT = 2;
  localparam int IRQ_C0_FLAG_BIT = 6;
  localparam int IRQ_C1_ENABLE_BIT = 0;
  localparam int IRQ_C1_FLAG_BIT = 4;
  localparam int PORT_FREQ_BIT = 3;
  // ---------------------------------------------------------------
  // Reset values and constants
  // ---------------------------------------------------------------
  localparam logic [7:0] C0_CTRL_RESET = 8'h08;
  localparam logic [7:0] C1_CTRL_RESET = 8'h08;
  localparam logic [7:0] C0_CTRL_WMASK = 8'hDF;
  localparam logic [7:0] C1_CTRL_WMASK = 8'hF8;
  localparam logic [7:0] PORT_A_RESET = 8'hFF;
  localparam logic [15:0] COUNT_MAX = 16'hFFFF;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  localparam logic [1:0] MODE_EVENT = 2'h1;
  localparam logic [1:0] MODE_TIMER = 2'h2;
  localparam logic [1:0] MODE_PULSE = 2'h3;
  localparam int unsigned SYS_CLK_HZ = 10000000;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] count;
    logic [15:0] preload;
    logic [7:0] low_buf;
    logic [7:0] ctrl;
    logic meas_active;
    logic meas_done;
    logic overflow;
    logic ctrl_loaded;
  } counter_state_t;
endpackage
